// *** verilog/snf_pkg.sv ***
// snf_pkg: constants for the serial nvram command front end.
// assumes one system clock of 50 mhz and a link clock driven by the master.
package snf_pkg;
  localparam logic [7:0] STATUS_READ_OP = 8'h05;
  localparam logic [7:0] STATUS_READ_FAST_OP = 8'h09;
  localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
  localparam logic [7:0] SET_WRITE_LATCH_OP = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_OP = 8'h04;
  localparam logic [7:0] ARRAY_READ_OP = 8'h03;
  localparam logic [7:0] ARRAY_READ_FAST_OP = 8'h0b;
  localparam logic [7:0] ARRAY_WRITE_OP = 8'h02;
  localparam logic [7:0] CLOCK_REG_READ_OP = 8'h13;
  localparam logic [7:0] CLOCK_REG_READ_QUICK_OP = 8'h1d;
  localparam logic [7:0] CLOCK_REG_WRITE_OP = 8'h12;
  localparam logic [7:0] SOFT_STORE_OP = 8'h3c;
  localparam logic [7:0] SOFT_RESTORE_OP = 8'h60;
  localparam logic [7:0] AUTO_SAVE_ON_OP = 8'h59;
  localparam logic [7:0] AUTO_SAVE_OFF_OP = 8'h19;
  localparam logic [7:0] SLEEP_OP = 8'hb9;
  localparam logic [7:0] SERIAL_NO_WRITE_OP = 8'hc2;
  localparam logic [7:0] SERIAL_NO_READ_OP = 8'hc3;
  localparam logic [7:0] SERIAL_NO_READ_QUICK_OP = 8'hc9;
  localparam logic [7:0] IDENT_READ_OP = 8'h9f;
  localparam logic [7:0] IDENT_READ_QUICK_OP = 8'h99;
  localparam logic [7:0] RESERVED_OP = 8'h1e;
  // status byte layout
  localparam int ST_PROTECT_PIN = 7;
  localparam int ST_BLOCK_HI = 3;
  localparam int ST_BLOCK_LO = 2;
  localparam int ST_WRITE_LATCH = 1;
  localparam int ST_BUSY = 0;
  // link bit counts
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_END_BITS = 6'h10;
  localparam logic [5:0] COUNT_MAX = 6'h3f;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STANDBY_ENTRY_DELAY_NS = 100;
  localparam logic AUTO_SAVE_RESET = 1'b1;
  typedef enum logic [2:0]
  {
    PWR_OFF = 3'b000,
    PWR_RESTORE = 3'b001,
    PWR_READY = 3'b010,
    PWR_DRAIN = 3'b011,
    PWR_STORE = 3'b100
  } snf_pwr_t;
endpackage

// *** verilog/snf_front_end.sv ***
// snf_front_end: spi slave command front end with power sequencing.
// assumes sck and cs_n come from the master; core handles array, clock regs, id.
`timescale 1ns/100ps
`default_nettype none
module snf_front_end
#(
  parameter int POWERUP_RESTORE_TIME_NS = 20000000,
  parameter int POWERDOWN_DELAY_NS = 25000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic vcc_ok,
  input wire logic store_restore_busy,
  input wire logic saved_protect_pin_enable,
  input wire logic saved_block_protect_hi,
  input wire logic saved_block_protect_lo,
  output logic so_data,
  output logic so_oe_n,
  output logic hw_store_busy_pin_n,
  output logic standby,
  output logic sleep_mode,
  output logic spi_mode3,
  output logic write_latch,
  output logic protect_pin_enable,
  output logic block_protect_hi,
  output logic block_protect_lo,
  output logic auto_save_en,
  output logic store_req,
  output logic restore_req,
  output logic cmd_strobe,
  output logic [7:0] cmd_code
);
  import snf_pkg::*;

  localparam int RESTORE_CYCLES =
    (POWERUP_RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CYCLES = POWERDOWN_DELAY_NS / CLK_PERIOD_NS;
  localparam int STANDBY_CYCLES =
    (STANDBY_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // refuse timing parameters that round to less than one clock
  if (RESTORE_CYCLES < 1 || DELAY_CYCLES < 1 || STANDBY_CYCLES < 1)
  begin
    $error("timing parameters give less than one clock cycle");
  end

  // ----------------------------------------------------------------
  // link domain: shift, count, decode
  // ----------------------------------------------------------------
  logic [5:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;
  logic [7:0] wr_data_reg;
  logic op_known_reg;
  logic op_tgl_reg;
  logic wr_tgl_reg;
  logic mode3_reg;
  logic [7:0] st_meta_reg;
  logic [7:0] st_link_reg;
  logic [7:0] shift_next;
  logic [7:0] status_byte;

  assign shift_next = {shift_reg[6:0], si};

  // clock level at select decides mode
  always_ff @(negedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
      mode3_reg <= 1'b0;
    else
      mode3_reg <= sck;
  end

  // bit capture on rising edges; deselect clears the frame
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_reg <= 6'h00;
      shift_reg <= 8'h00;
      op_reg <= 8'h00;
      op_known_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != COUNT_MAX)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg == OPCODE_BITS - 6'h01)
      begin
        op_reg <= shift_next;
        op_known_reg <= (shift_next != RESERVED_OP) && known_op(shift_next);
      end
      if (bit_cnt_reg == DUMMY_END_BITS - 6'h01)
        wr_data_reg <= shift_next;
    end
  end

  // events toward the system clock; these survive deselect
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end
    else if (!cs_n)
    begin
      if (bit_cnt_reg == OPCODE_BITS - 6'h01)
        op_tgl_reg <= ~op_tgl_reg;
      if (bit_cnt_reg == DUMMY_END_BITS - 6'h01 && op_reg == STATUS_WRITE_OP)
        wr_tgl_reg <= ~wr_tgl_reg;
    end
  end

  // status byte brought into the link clock; quasi-static during a frame
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_meta_reg <= 8'h00;
      st_link_reg <= 8'h00;
    end
    else
    begin
      st_meta_reg <= status_byte;
      st_link_reg <= st_meta_reg;
    end
  end

  // serial output on falling edges, status reads only
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_oe_n <= 1'b1;
      so_data <= 1'b0;
    end
    else if (op_known_reg && ((op_reg == STATUS_READ_OP && bit_cnt_reg >= OPCODE_BITS) ||
             (op_reg == STATUS_READ_FAST_OP && bit_cnt_reg >= DUMMY_END_BITS)))
    begin
      so_oe_n <= 1'b0;
      so_data <= st_link_reg[~bit_cnt_reg[2:0]];
    end
    else
    begin
      so_oe_n <= 1'b1;
      so_data <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  logic [2:0] op_sync_reg;
  logic [2:0] wr_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] vcc_sync_reg;
  logic [1:0] mode_sync_reg;
  logic op_evt;
  logic wr_evt;
  logic cs_rise;
  logic cs_fall;
  logic vcc_s;

  // two stages each, third stage only for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_sync_reg <= 3'h0;
      wr_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      vcc_sync_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
    end
    else
    begin
      op_sync_reg <= {op_sync_reg[1:0], op_tgl_reg};
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      vcc_sync_reg <= {vcc_sync_reg[0], vcc_ok};
      mode_sync_reg <= {mode_sync_reg[0], mode3_reg};
    end
  end

  assign op_evt = op_sync_reg[2] ^ op_sync_reg[1];
  assign wr_evt = wr_sync_reg[2] ^ wr_sync_reg[1];
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign vcc_s = vcc_sync_reg[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      spi_mode3 <= 1'b0;
    else
      spi_mode3 <= mode_sync_reg[1];
  end

  // ----------------------------------------------------------------
  // power sequencing
  // ----------------------------------------------------------------
  snf_pwr_t pwr_reg;
  logic [31:0] tmr_reg;
  logic dirty_reg;
  logic write_open_reg;
  logic seen_busy_reg;
  logic accept;
  logic needs_latch;
  logic is_write;

  assign accept = op_evt && pwr_reg == PWR_READY && vcc_s && !store_restore_busy
                  && op_known_reg;
  assign needs_latch = op_reg == STATUS_WRITE_OP || is_write ||
                       op_reg == SOFT_STORE_OP || op_reg == SOFT_RESTORE_OP ||
                       op_reg == AUTO_SAVE_ON_OP || op_reg == AUTO_SAVE_OFF_OP;
  assign is_write = op_reg == ARRAY_WRITE_OP || op_reg == CLOCK_REG_WRITE_OP ||
                    op_reg == SERIAL_NO_WRITE_OP;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_reg <= PWR_OFF;
      tmr_reg <= 32'h0;
      seen_busy_reg <= 1'b0;
    end
    else
    begin
      unique case (pwr_reg)
        PWR_OFF:
          if (vcc_s)
          begin
            pwr_reg <= PWR_RESTORE;
            tmr_reg <= 32'h0;
          end
        PWR_RESTORE:
          if (tmr_reg == 32'(RESTORE_CYCLES - 1))
            pwr_reg <= PWR_READY;
          else
            tmr_reg <= tmr_reg + 32'h1;
        PWR_READY:
          if (!vcc_s)
          begin
            pwr_reg <= PWR_DRAIN;
            tmr_reg <= 32'h0;
          end
        PWR_DRAIN:
          if (!write_open_reg || tmr_reg == 32'(DELAY_CYCLES - 1))
          begin
            pwr_reg <= (dirty_reg && auto_save_en) ? PWR_STORE : PWR_OFF;
            seen_busy_reg <= 1'b0;
          end
          else
            tmr_reg <= tmr_reg + 32'h1;
        PWR_STORE:
          if (store_restore_busy)
            seen_busy_reg <= 1'b1;
          else if (seen_busy_reg)
            pwr_reg <= PWR_OFF;
        default:
          pwr_reg <= PWR_OFF;
      endcase
    end
  end

  // busy pin low during restore, drain and store
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hw_store_busy_pin_n <= 1'b0;
    else
      hw_store_busy_pin_n <= pwr_reg == PWR_READY && !store_restore_busy;
  end

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_strobe <= 1'b0;
      cmd_code <= 8'h00;
      store_req <= 1'b0;
      restore_req <= 1'b0;
    end
    else
    begin
      cmd_strobe <= accept && (!needs_latch || write_latch);
      cmd_code <= accept ? op_reg : cmd_code;
      store_req <= (accept && write_latch && op_reg == SOFT_STORE_OP) ||
                   (pwr_reg == PWR_DRAIN && dirty_reg && auto_save_en &&
                    (!write_open_reg || tmr_reg == 32'(DELAY_CYCLES - 1)));
      restore_req <= accept && write_latch && op_reg == SOFT_RESTORE_OP;
    end
  end

  // write latch; cleared at deselect after a guarded instruction
  logic latch_clr_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_latch <= 1'b0;
      latch_clr_reg <= 1'b0;
    end
    else if (pwr_reg == PWR_RESTORE)
    begin
      write_latch <= 1'b0;
      latch_clr_reg <= 1'b0;
    end
    else
    begin
      if (accept && op_reg == SET_WRITE_LATCH_OP)
        write_latch <= 1'b1;
      else if (cs_rise && latch_clr_reg)
        write_latch <= 1'b0;
      if (accept && (op_reg == CLEAR_WRITE_LATCH_OP || (needs_latch && write_latch)))
        latch_clr_reg <= 1'b1;
      else if (cs_rise)
        latch_clr_reg <= 1'b0;
    end
  end

  // nonvolatile status bits and automatic save enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protect_pin_enable <= 1'b0;
      block_protect_hi <= 1'b0;
      block_protect_lo <= 1'b0;
      auto_save_en <= AUTO_SAVE_RESET;
    end
    else if (pwr_reg == PWR_OFF && vcc_s)
    begin
      protect_pin_enable <= saved_protect_pin_enable;
      block_protect_hi <= saved_block_protect_hi;
      block_protect_lo <= saved_block_protect_lo;
      auto_save_en <= AUTO_SAVE_RESET;
    end
    else
    begin
      if (wr_evt && write_latch && pwr_reg == PWR_READY && vcc_s)
      begin
        protect_pin_enable <= wr_data_reg[ST_PROTECT_PIN];
        block_protect_hi <= wr_data_reg[ST_BLOCK_HI];
        block_protect_lo <= wr_data_reg[ST_BLOCK_LO];
      end
      if (accept && write_latch && op_reg == AUTO_SAVE_ON_OP)
        auto_save_en <= 1'b1;
      else if (accept && write_latch && op_reg == AUTO_SAVE_OFF_OP)
        auto_save_en <= 1'b0;
    end
  end

  // written-since-restore flag; a new write beats the restore clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirty_reg <= 1'b0;
      write_open_reg <= 1'b0;
    end
    else
    begin
      if (accept && write_latch && (is_write || op_reg == STATUS_WRITE_OP))
        dirty_reg <= 1'b1;
      else if (pwr_reg == PWR_RESTORE || restore_req)
        dirty_reg <= 1'b0;
      if (accept && write_latch && is_write)
        write_open_reg <= 1'b1;
      else if (cs_rise)
        write_open_reg <= 1'b0;
    end
  end

  // sleep until next select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_mode <= 1'b0;
    else if (accept && op_reg == SLEEP_OP)
      sleep_mode <= 1'b1;
    else if (cs_fall)
      sleep_mode <= 1'b0;
  end

  // standby after deselect delay, held off while busy
  logic [31:0] sb_cnt_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sb_cnt_reg <= 32'h0;
      standby <= 1'b0;
    end
    else if (!cs_sync_reg[1])
    begin
      sb_cnt_reg <= 32'h0;
      standby <= 1'b0;
    end
    else if (pwr_reg != PWR_READY || store_restore_busy)
      sb_cnt_reg <= 32'h0;
    else if (sb_cnt_reg == 32'(STANDBY_CYCLES - 1))
      standby <= 1'b1;
    else
      sb_cnt_reg <= sb_cnt_reg + 32'h1;
  end

  // status byte seen by status reads
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[ST_PROTECT_PIN] = protect_pin_enable;
    status_byte[ST_BLOCK_HI] = block_protect_hi;
    status_byte[ST_BLOCK_LO] = block_protect_lo;
    status_byte[ST_WRITE_LATCH] = write_latch;
    status_byte[ST_BUSY] = store_restore_busy || pwr_reg != PWR_READY;
  end

  // opcode table check
  function automatic logic known_op(input logic [7:0] op);
    unique case (op)
      STATUS_READ_OP, STATUS_READ_FAST_OP, STATUS_WRITE_OP, SET_WRITE_LATCH_OP,
      CLEAR_WRITE_LATCH_OP, ARRAY_READ_OP, ARRAY_READ_FAST_OP, ARRAY_WRITE_OP,
      CLOCK_REG_READ_OP, CLOCK_REG_READ_QUICK_OP, CLOCK_REG_WRITE_OP, SOFT_STORE_OP,
      SOFT_RESTORE_OP, AUTO_SAVE_ON_OP, AUTO_SAVE_OFF_OP, SLEEP_OP, SERIAL_NO_WRITE_OP,
      SERIAL_NO_READ_OP, SERIAL_NO_READ_QUICK_OP, IDENT_READ_OP, IDENT_READ_QUICK_OP:
        known_op = 1'b1;
      default:
        known_op = 1'b0;
    endcase
  endfunction
endmodule
`default_nettype wire

// *** bench/snf_front_end_assertions.sv ***
// checker: port-level properties of the command front end
// assumes a bind onto snf_front_end; clk and sck domains
`timescale 1ns/100ps
`default_nettype none
module snf_chk
  import snf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic vcc_ok,
  input wire logic so_data,
  input wire logic so_oe_n,
  input wire logic hw_store_busy_pin_n,
  input wire logic standby,
  input wire logic sleep_mode,
  input wire logic write_latch,
  input wire logic auto_save_en,
  input wire logic store_req,
  input wire logic restore_req,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code
);
  logic so_at_rise;
  // output level held over each sck rise
  always_ff @(posedge sck)
  begin
    so_at_rise <= so_data;
  end
  AST_OE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n && $past(cs_n) |-> so_oe_n) else $error("so driven while deselected");
  AST_SO_FALL: assert property (@(negedge sck) disable iff (!rst_n || cs_n)
    !so_oe_n |-> so_data == so_at_rise) else $error("so moved on a rise");
  AST_STROBE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_strobe |=> !cmd_strobe) else $error("strobe too long");
  AST_STORE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    store_req |=> !store_req) else $error("store request too long");
  AST_RESTORE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    restore_req |=> !restore_req) else $error("restore request too long");
  AST_BUSY_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
    !hw_store_busy_pin_n && $past(!hw_store_busy_pin_n, 6) |-> !cmd_strobe)
    else $error("opcode taken while busy");
  AST_VCC_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
    (!vcc_ok) [*8] |-> !cmd_strobe) else $error("opcode taken without supply");
  AST_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    (!cs_n) [*5] |-> !standby) else $error("standby while selected");
  AST_STANDBY_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(standby) |-> $past(cs_n, 2) && $past(cs_n, 6)) else $error("standby too early");
  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(cs_n) |-> ##[1:5] !sleep_mode) else $error("sleep kept after select");
  AST_LATCH_ON: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_strobe && cmd_code == SET_WRITE_LATCH_OP |-> ##[0:3] write_latch)
    else $error("latch not set");
  AST_AUTO_ON: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_strobe && cmd_code == AUTO_SAVE_ON_OP |-> ##[0:3] auto_save_en)
    else $error("auto save not enabled");
  // main scenarios reached
  COV_STORE: cover property (@(posedge clk) store_req);
  COV_RESTORE: cover property (@(posedge clk) restore_req);
  COV_SLEEP: cover property (@(posedge clk) $rose(sleep_mode));
endmodule
bind snf_front_end snf_chk u_chk (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
  .vcc_ok(vcc_ok), .so_data(so_data), .so_oe_n(so_oe_n),
  .hw_store_busy_pin_n(hw_store_busy_pin_n), .standby(standby),
  .sleep_mode(sleep_mode), .write_latch(write_latch), .auto_save_en(auto_save_en),
  .store_req(store_req), .restore_req(restore_req), .cmd_strobe(cmd_strobe),
  .cmd_code(cmd_code));
`default_nettype wire

// *** bench/snf_spi_master.sv ***
// spi master model: one frame of opcode and data bytes, reads so
// assumes mode chosen per frame; link clock period 125 ns
`timescale 1ns/100ps
`default_nettype none
module snf_spi_master
(
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_data,
  input wire logic so_oe_n
);
  logic saw_drive;
  initial
  begin
    sck = 1'b0;
    si = 1'b0;
    saw_drive = 1'b0;
    // deselect edge after time zero so the slave surely sees it
    #1 cs_n = 1'b1;
  end
  // one opcode per select period, msb first, clock parked per mode
  task automatic frame(input logic m3, input logic [31:0] tx, input int nb,
    output logic [7:0] rx);
    int i;
    rx = 8'h00;
    saw_drive = 1'b0;
    sck = m3;
    #62.5 cs_n = 1'b0;
    for (i = nb * 8 - 1; i >= 0; i--)
    begin
      #62.5 sck = 1'b0;
      si = tx[i];
      #62.5 sck = 1'b1;
      rx = {rx[6:0], so_oe_n ? 1'b1 : so_data}; // released line reads pulled up
      if (so_oe_n === 1'b0)
        saw_drive = 1'b1;
    end
    #62.5 sck = m3;
    #62.5 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule
`default_nettype wire

// *** bench/test_spi_nvram_command_front_end.sv ***
// testbench: drives the front end through the spi master model
// assumes snf_pkg, the design and the checker bind compiled first
`timescale 1ns/100ps
`default_nettype none
module test_spi_nvram_command_front_end;
  import snf_pkg::*;
  localparam logic [7:0] OPS [16] = '{ARRAY_READ_OP, ARRAY_READ_FAST_OP, ARRAY_WRITE_OP,
    CLOCK_REG_READ_OP, CLOCK_REG_READ_QUICK_OP, CLOCK_REG_WRITE_OP, SOFT_STORE_OP,
    SOFT_RESTORE_OP, AUTO_SAVE_OFF_OP, AUTO_SAVE_ON_OP, SERIAL_NO_WRITE_OP,
    SERIAL_NO_READ_OP, SERIAL_NO_READ_QUICK_OP, IDENT_READ_OP, IDENT_READ_QUICK_OP, SLEEP_OP};
  logic clk, rst_n, vcc_ok, busy, spe, sbh, sbl, so_data, so_oe_n, hsb_n, standby;
  logic sleep_mode, mode3, wl, pe, bh, bl, ase, st_req, rs_req, strobe;
  logic [7:0] code, rx;
  wire logic sck, cs_n, si;
  int err_count = 0, total_checks = 0, cyc = 0, n_strobe = 0, n_store = 0;
  int n_restore = 0, bcnt = 0;
  snf_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .so_data(so_data), .so_oe_n(so_oe_n));
  snf_front_end #(.POWERUP_RESTORE_TIME_NS(200), .POWERDOWN_DELAY_NS(100)) uut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .vcc_ok(vcc_ok),
    .store_restore_busy(busy), .saved_protect_pin_enable(spe),
    .saved_block_protect_hi(sbh), .saved_block_protect_lo(sbl), .so_data(so_data),
    .so_oe_n(so_oe_n), .hw_store_busy_pin_n(hsb_n), .standby(standby),
    .sleep_mode(sleep_mode), .spi_mode3(mode3), .write_latch(wl),
    .protect_pin_enable(pe), .block_protect_hi(bh), .block_protect_lo(bl),
    .auto_save_en(ase), .store_req(st_req), .restore_req(rs_req), .cmd_strobe(strobe),
    .cmd_code(code));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // pulse tallies, timeout, and a core that stays busy after each request
  always @(posedge clk)
  begin
    cyc++;
    if (strobe === 1'b1)
      n_strobe++;
    if (st_req === 1'b1)
      n_store++;
    if (rs_req === 1'b1)
      n_restore++;
    bcnt = (st_req === 1'b1 || rs_req === 1'b1) ? 6 : (bcnt > 0 ? bcnt - 1 : 0);
    #2 busy = (bcnt != 0);
    if (cyc == 30000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one frame, then let the strobe land and the core settle
  task op(input logic m3, input logic [31:0] tx, input int nb);
    int k;
    m.frame(m3, tx, nb, rx);
    tick(12);
    for (k = 0; k < 40 && busy; k++)
      tick(1);
    tick(2);
  endtask
  task wait_ready;
    int k;
    for (k = 0; k < 100 && hsb_n !== 1'b1; k++)
      tick(1);
    chk(hsb_n === 1'b1, "restore did not end");
  endtask
  task t_power_up;
    vcc_ok = 1'b1;
    tick(5);
    chk(hsb_n === 1'b0, "no busy during restore");
    wait_ready();
    chk({pe, bh, bl, wl} === 4'b1010, "power-up status");
    tick(10);
    chk(standby === 1'b1 && sleep_mode === 1'b0, "not in standby");
    $display("test power_up done");
  endtask
  task t_status;
    op(1'b0, {16'h0, STATUS_READ_OP, 8'h00}, 2);
    chk(rx === 8'h84 && mode3 === 1'b0, "mode 0 status read");
    op(1'b1, {24'h0, SET_WRITE_LATCH_OP}, 1);
    chk(wl === 1'b1 && mode3 === 1'b1, "latch set in mode 3");
    op(1'b1, {8'h0, STATUS_READ_FAST_OP, 16'h0}, 3);
    chk(rx === 8'h86, "fast status read");
    op(1'b0, {24'h0, CLEAR_WRITE_LATCH_OP}, 1);
    chk(wl === 1'b0, "latch not cleared");
    op(1'b0, {24'h0, SET_WRITE_LATCH_OP}, 1);
    op(1'b0, {16'h0, STATUS_WRITE_OP, 8'h08}, 2);
    chk({pe, bh, bl, wl} === 4'b0100, "status write");
    op(1'b1, {16'h0, STATUS_READ_OP, 8'h00}, 2);
    chk(rx === 8'h08, "status after write");
    $display("test status done");
  endtask
  task t_table;
    int i, ns, nst, nrs;
    for (i = 0; i < 16; i++)
    begin
      op(1'b0, {24'h0, SET_WRITE_LATCH_OP}, 1);
      ns = n_strobe;
      nst = n_store;
      nrs = n_restore;
      op(i[0], {24'h0, OPS[i]}, 1);
      chk(n_strobe == ns + 1 && code === OPS[i], "opcode not taken");
      chk((n_store - nst == 32'(OPS[i] == SOFT_STORE_OP)) &&
        (n_restore - nrs == 32'(OPS[i] == SOFT_RESTORE_OP)), "store or restore");
      if (OPS[i] == AUTO_SAVE_OFF_OP)
        chk(ase === 1'b0, "auto save still on");
    end
    chk(ase === 1'b1 && sleep_mode === 1'b1, "auto save or sleep");
    op(1'b0, {16'h0, STATUS_READ_OP, 8'h00}, 2);
    chk(sleep_mode === 1'b0, "no wake");
    $display("test table done");
  endtask
  task t_refused;
    int ns, nst;
    ns = n_strobe;
    nst = n_store;
    op(1'b0, {16'h0, RESERVED_OP, 8'hff}, 2);
    chk(n_strobe == ns && m.saw_drive === 1'b0, "reserved taken");
    op(1'b1, {16'h0, 8'hff, STATUS_READ_OP}, 2);
    chk(n_strobe == ns && m.saw_drive === 1'b0, "unknown taken");
    op(1'b0, {24'h0, CLEAR_WRITE_LATCH_OP}, 1);
    chk(wl === 1'b0, "latch left set");
    op(1'b0, {24'h0, SOFT_STORE_OP}, 1);
    chk(n_store == nst, "store without latch");
    $display("test refused done");
  endtask
  task t_power_down;
    int k, nst;
    op(1'b0, {24'h0, SET_WRITE_LATCH_OP}, 1);
    op(1'b0, {ARRAY_WRITE_OP, 24'h000155}, 4);
    nst = n_store;
    vcc_ok = 1'b0;
    for (k = 0; k < 60 && n_store == nst; k++)
      tick(1);
    chk(n_store == nst + 1, "no save on supply loss");
    tick(20);
    op(1'b0, {24'h0, SET_WRITE_LATCH_OP}, 1);
    chk(wl === 1'b0, "answered without supply");
    spe = 1'b0;
    sbh = 1'b1;
    vcc_ok = 1'b1;
    wait_ready();
    chk({pe, bh, bl, wl} === 4'b0110, "saved bits not loaded");
    nst = n_store;
    vcc_ok = 1'b0;
    tick(60);
    chk(n_store == nst, "save without write");
    $display("test power_down done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    vcc_ok = 1'b0;
    busy = 1'b0;
    spe = 1'b1;
    sbh = 1'b0;
    sbl = 1'b1;
    tick(4);
    rst_n = 1'b1;
    t_power_up();
    t_status();
    t_table();
    t_refused();
    t_power_down();
    give_verdict();
  end
endmodule
`default_nettype wire
